// >>> design/fpec_ctrl.sv
/*
 Flash program/erase sequencer between the core and the flash array.
 Assumes all inputs come from logic on clk_i; the array returns read data
 combinationally in the cycle fl_rd_o is high.
*/
`timescale 1ns/1ps
module fpec_ctrl #(
  parameter int unsigned ERASE_CYCLES_P = fpec_pkg::ERASE_CYCLES,
  parameter int unsigned WRITE_CYCLES_P = fpec_pkg::WRITE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic store_write_enable_i,
  input wire logic store_erase_enable_i,
  input wire logic software_flash_enable_i,
  input wire logic scratchpad_select_i,
  input wire logic block_write_select_i,
  input wire logic [1:0] code_bank_field_i,
  input wire logic dw_valid_i,
  input wire logic [fpec_pkg::LOG_AW-1:0] dw_addr_i,
  input wire logic [7:0] dw_data_i,
  output logic dw_ready_o,
  input wire logic dr_valid_i,
  input wire logic [fpec_pkg::LOG_AW-1:0] dr_addr_i,
  input wire logic cr_valid_i,
  input wire logic cr_fetch_i,
  input wire logic [fpec_pkg::LOG_AW-1:0] cr_addr_i,
  output logic cr_ready_o,
  output logic cr_rvalid_o,
  output logic [7:0] cr_data_o,
  output logic external_data_ram_we_o,
  output logic [fpec_pkg::LOG_AW-1:0] external_data_ram_waddr_o,
  output logic [7:0] external_data_ram_wdata_o,
  output logic external_data_ram_re_o,
  output logic [fpec_pkg::LOG_AW-1:0] external_data_ram_raddr_o,
  output logic fl_rd_o,
  output logic fl_prog_o,
  output logic fl_erase_o,
  output logic [fpec_pkg::PHYS_AW-1:0] fl_addr_o,
  output logic [31:0] fl_wdata_o,
  output logic [3:0] fl_wmask_o,
  output logic [fpec_pkg::LEN_W-1:0] fl_erase_len_o,
  input wire logic [31:0] fl_rdata_i,
  input wire logic [fpec_pkg::IRQ_N-1:0] irq_req_i,
  input wire logic [fpec_pkg::IRQ_N-1:0] irq_cached_i,
  input wire logic [fpec_pkg::IRQ_N-1:0] irq_ack_i,
  output logic [fpec_pkg::IRQ_N-1:0] irq_o,
  output logic flash_busy_flag_o
);
  import fpec_pkg::*;

  typedef struct packed {
    fpec_state_type st;
    logic fl_rd;
    logic fl_prog;
    logic fl_erase;
    logic [PHYS_AW-1:0] fl_addr;
    logic [31:0] fl_wdata;
    logic [3:0] fl_wmask;
    logic [LEN_W-1:0] erase_len;
    logic [31:0] new_data;
    logic [3:0] new_mask;
    logic [31:0] blk_data;
    logic [3:0] blk_mask;
    logic tmr_start;
    logic [TMR_W-1:0] tmr_len;
    logic external_data_ram_we;
    logic [LOG_AW-1:0] external_data_ram_waddr;
    logic [7:0] external_data_ram_wdata;
    logic external_data_ram_re;
    logic [LOG_AW-1:0] external_data_ram_raddr;
    logic cr_pend;
    logic cr_undef;
    logic [1:0] cr_lane;
    logic cr_rvalid;
    logic [7:0] cr_data;
    logic [IRQ_N-1:0] irq_pend;
  } fpec_ctrl_type;

  fpec_ctrl_type s_q;
  fpec_ctrl_type s_d;

  logic idle;
  logic tmr_done;
  logic [31:0] merge_data;
  logic [PHYS_AW-1:0] cr_phys;
  logic [PHYS_AW-1:0] dw_phys;
  logic cr_scr;
  logic cr_undef;
  logic dw_scr;
  logic dw_both;
  logic dw_undef;
  logic dw_last;
  logic [3:0] dw_lane;
  logic dw_fl;
  logic fl_cmd;
  logic [IRQ_N-1:0] irq_elig;

  // Lower window is always bank 0; upper window follows the bank field
  function automatic logic [PHYS_AW-1:0] map_code(
    input logic [LOG_AW-1:0] a,
    input logic [1:0] bank
  );
    logic [PHYS_AW-1:0] p;
    p = '0;
    p[BANK_LSB-1:0] = a[BANK_LSB-1:0];
    if (a[LOG_AW-1]) begin
      p[BANK_LSB +: 2] = bank;
    end
    return p;
  endfunction : map_code

  assign idle = (s_q.st == ST_IDLE);
  // Fetches ignore the scratchpad select so code never runs from it
  assign cr_scr = scratchpad_select_i && !cr_fetch_i &&
                  (cr_addr_i <= SCRATCH_LAST);
  assign cr_undef = scratchpad_select_i && !cr_fetch_i && !cr_scr;
  assign cr_phys = cr_scr ? (SCRATCH_BASE | PHYS_AW'(cr_addr_i[7:0]))
                          : map_code(cr_addr_i, code_bank_field_i);
  assign dw_scr = scratchpad_select_i && (dw_addr_i <= SCRATCH_LAST);
  assign dw_both = scratchpad_select_i && store_erase_enable_i &&
                   (dw_addr_i == ERASE_BOTH_ADDR);
  assign dw_undef = scratchpad_select_i && !dw_scr && !dw_both;
  assign dw_phys = dw_scr ? (SCRATCH_BASE | PHYS_AW'(dw_addr_i[7:0]))
                          : map_code(dw_addr_i, code_bank_field_i);
  assign dw_lane = 4'(4'h1 << dw_phys[1:0]);
  // Block ends at lane 3 in code space, at odd byte in scratchpad
  assign dw_last = dw_scr ? dw_phys[0]
                          : (dw_phys[1:0] == CODE_LAST_LANE);
  // Flash-bound writes wait for an idle sequencer and a quiet read port
  assign dw_ready_o = !store_write_enable_i ||
                      (idle && !cr_valid_i);
  assign dw_fl = dw_valid_i && store_write_enable_i && idle && !cr_valid_i;
  assign fl_cmd = dw_fl && software_flash_enable_i && !dw_undef;
  generate
    for (genvar g = 0; g < 4; g++) begin : g_lane
      assign merge_data[8*g +: 8] = fl_rdata_i[8*g +: 8] &
        (s_q.new_mask[g] ? s_q.new_data[8*g +: 8] : ERASED_BYTE);
    end
  endgenerate
  always_comb begin
    s_d = s_q;
    s_d.fl_rd = 1'b0;
    s_d.fl_prog = 1'b0;
    s_d.fl_erase = 1'b0;
    s_d.tmr_start = 1'b0;
    s_d.external_data_ram_we = 1'b0;
    s_d.external_data_ram_re = 1'b0;
    s_d.cr_rvalid = 1'b0;
    s_d.cr_pend = 1'b0;
    // Request landing on its acknowledge cycle stays pending
    s_d.irq_pend = (s_q.irq_pend & ~irq_ack_i) | irq_req_i;
    if (dr_valid_i) begin
      s_d.external_data_ram_re = 1'b1;
      s_d.external_data_ram_raddr = dr_addr_i;
    end
    if (dw_valid_i && !store_write_enable_i) begin
      s_d.external_data_ram_we = 1'b1;
      s_d.external_data_ram_waddr = dw_addr_i;
      s_d.external_data_ram_wdata = dw_data_i;
    end
    if (cr_valid_i && idle) begin
      s_d.cr_pend = 1'b1;
      s_d.cr_undef = cr_undef;
      s_d.cr_lane = cr_phys[1:0];
      s_d.fl_rd = !cr_undef;
      s_d.fl_addr = cr_phys & WORD_MASK;
    end
    if (s_q.cr_pend) begin
      s_d.cr_rvalid = 1'b1;
      s_d.cr_data = s_q.cr_undef ? ERASED_BYTE
                                 : fl_rdata_i[8*s_q.cr_lane +: 8];
    end
    case (s_q.st)
      ST_IDLE: begin
        if (fl_cmd && store_erase_enable_i) begin
          s_d.st = ST_BUSY;
          s_d.fl_erase = 1'b1;
          s_d.tmr_start = 1'b1;
          s_d.tmr_len = TMR_W'(ERASE_CYCLES_P);
          if (dw_both) begin
            s_d.fl_addr = SCRATCH_BASE;
            s_d.erase_len = BOTH_LEN;
          end else if (dw_scr) begin
            s_d.fl_addr = dw_phys & SECTOR_MASK;
            s_d.erase_len = SECTOR_LEN;
          end else begin
            s_d.fl_addr = dw_phys & PAGE_MASK;
            s_d.erase_len = PAGE_LEN;
          end
        end else if (fl_cmd && block_write_select_i && !dw_last) begin
          // Partial block is only collected, no array access yet
          s_d.blk_data = s_q.blk_data;
          s_d.blk_data[8*dw_phys[1:0] +: 8] = dw_data_i;
          s_d.blk_mask = s_q.blk_mask | dw_lane;
        end else if (fl_cmd) begin
          s_d.st = ST_RD_TAKE;
          s_d.fl_rd = 1'b1;
          s_d.fl_addr = dw_phys & WORD_MASK;
          s_d.new_data = block_write_select_i ? s_q.blk_data : '0;
          s_d.new_data[8*dw_phys[1:0] +: 8] = dw_data_i;
          s_d.new_mask = dw_lane |
            (block_write_select_i ? s_q.blk_mask : 4'h0);
          s_d.blk_mask = 4'h0;
        end
      end
      ST_RD_TAKE: begin
        // Merge with the old word so programming never sets a bit
        s_d.fl_wdata = merge_data;
        s_d.fl_wmask = s_q.new_mask;
        s_d.fl_prog = 1'b1;
        s_d.tmr_start = 1'b1;
        s_d.tmr_len = TMR_W'(WRITE_CYCLES_P);
        s_d.st = ST_BUSY;
      end
      ST_BUSY: begin
        if (tmr_done) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  fpec_timer u_timer (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .start_i(s_q.tmr_start),
    .len_i(s_q.tmr_len),
    .done_o(tmr_done)
  );
  // Only cache-resident handlers may run during an operation
  assign irq_elig = s_q.irq_pend &
                    (idle ? {IRQ_N{1'b1}} : irq_cached_i);
  assign irq_o = irq_elig & (~irq_elig + IRQ_N'(1));
  assign flash_busy_flag_o = !idle;
  assign cr_ready_o = idle;
  assign cr_rvalid_o = s_q.cr_rvalid;
  assign cr_data_o = s_q.cr_data;
  assign external_data_ram_we_o = s_q.external_data_ram_we;
  assign external_data_ram_waddr_o = s_q.external_data_ram_waddr;
  assign external_data_ram_wdata_o = s_q.external_data_ram_wdata;
  assign external_data_ram_re_o = s_q.external_data_ram_re;
  assign external_data_ram_raddr_o = s_q.external_data_ram_raddr;
  assign fl_rd_o = s_q.fl_rd;
  assign fl_prog_o = s_q.fl_prog;
  assign fl_erase_o = s_q.fl_erase;
  assign fl_addr_o = s_q.fl_addr;
  assign fl_wdata_o = s_q.fl_wdata;
  assign fl_wmask_o = s_q.fl_wmask;
  assign fl_erase_len_o = s_q.erase_len;

  // Helper for the timing check: busy length and kind of last operation
  int busy_cnt_q;
  logic was_erase_q;
  always_ff @(posedge clk_i) begin
    if (!rstn_i || idle) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 1;
    end
    if (!rstn_i) begin
      was_erase_q <= 1'b0;
    end else if (s_q.fl_erase) begin
      was_erase_q <= 1'b1;
    end else if (s_q.fl_prog) begin
      was_erase_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_prog_clears_only: assert property (
    fl_prog_o |-> (fl_wdata_o & ~$past(fl_rdata_i)) == 32'h0)
    else $error("Program would set a flash bit");
  a_erase_busy: assert property (
    fl_erase_o |-> flash_busy_flag_o [*4])
    else $error("Busy flag dropped during erase");
  a_op_length: assert property (
    $fell(flash_busy_flag_o) |-> busy_cnt_q ==
      (was_erase_q ? int'(ERASE_CYCLES_P) + 1 : int'(WRITE_CYCLES_P) + 2))
    else $error("Operation time differs from its nominal count");
  a_fetch_stall: assert property (
    flash_busy_flag_o |-> !cr_ready_o && (!fl_rd_o || s_q.st == ST_RD_TAKE))
    else $error("Code fetch served while flash busy");
  a_irq_held: assert property (
    flash_busy_flag_o |-> (irq_o & ~irq_cached_i) == '0)
    else $error("Uncached interrupt released during operation");
  a_external_data_ram_route: assert property (
    dw_valid_i && !store_write_enable_i |=> external_data_ram_we_o && !fl_erase_o)
    else $error("Data write not sent to external RAM");
  a_read_external_data_ram: assert property (
    dr_valid_i |=> external_data_ram_re_o && external_data_ram_raddr_o == $past(dr_addr_i))
    else $error("Data read not sent to external RAM");
  a_bank_map: assert property (
    cr_valid_i && cr_ready_o && !scratchpad_select_i |=>
      fl_addr_o[BANK_LSB +: 2] ==
      ($past(cr_addr_i[LOG_AW-1]) ? $past(code_bank_field_i) : 2'h0))
    else $error("Upper window bank mapping wrong");
  a_no_scratch_exec: assert property (
    cr_valid_i && cr_ready_o && cr_fetch_i |=> !fl_addr_o[PHYS_AW-1])
    else $error("Instruction fetch reached scratchpad");
  a_erase_page: assert property (
    fl_erase_o && !fl_addr_o[PHYS_AW-1] |->
      fl_erase_len_o == PAGE_LEN && (fl_addr_o & ~PAGE_MASK) == '0)
    else $error("Main erase not page aligned");
  a_erase_both: assert property (
    fl_cmd && dw_both |=>
      fl_erase_o && fl_addr_o == SCRATCH_BASE && fl_erase_len_o == BOTH_LEN)
    else $error("Both-sector erase not issued");
  a_single_start: assert property (
    fl_cmd && !store_erase_enable_i && !block_write_select_i |=>
      fl_rd_o ##1 fl_prog_o && $countones(fl_wmask_o) == 1)
    else $error("Single byte write not started");
  a_block_wait: assert property (
    fl_cmd && !store_erase_enable_i && block_write_select_i && !dw_last |=>
      idle && !flash_busy_flag_o)
    else $error("Block write started before last byte");
  a_hold_off: assert property (
    flash_busy_flag_o && store_write_enable_i |-> !dw_ready_o)
    else $error("Flash write accepted while busy");
  a_disabled_quiet: assert property (
    dw_fl && !software_flash_enable_i |=> !flash_busy_flag_o)
    else $error("Disabled write raised busy");

  c_erase: cover property (fl_erase_o ##1 flash_busy_flag_o);
  c_block: cover property (fl_prog_o && fl_wmask_o == 4'hf);
  c_irq_busy: cover property (flash_busy_flag_o && irq_o != '0);
endmodule : fpec_ctrl

// >>> design/fpec_pkg.sv
/*
 Constants, state encoding and timing for the flash program/erase sequencer.
 Assumes a 250 MHz system clock and a synchronous active-low reset.
*/
// Notes on behaviour
// - Programming only clears bits; erase sets all-ones
// - Busy flag high for whole erase or write
// - Flash fetches stall while an operation runs
// - Uncached interrupts held pending, then priority order
// - Write enable redirects data writes to flash
// - Write enable is never cleared by hardware
// - Data reads always go to external RAM
// - Code reads, writes, erases use bank mapping
// - Bank field maps upper window; lower is bank0
// - Scratchpad select maps lowest 256 addresses to scratchpad
// - No instruction fetch from scratchpad sectors
// - Erase clears whole page: 1024 or 128 bytes
// - Three enables set: data write erases page
// - Special address erases both scratchpad sectors together
// - Single mode programs one byte per write
// - Block mode: four bytes code, two scratchpad
// - Code block buffered, written after byte 11b
// - Scratchpad block written after byte ending 1b
// - Erase and write timed internally by hardware
package fpec_pkg;
  localparam int unsigned LOG_AW = 16;
  localparam int unsigned PHYS_AW = 18;
  localparam int unsigned BANK_LSB = 15;
  localparam int unsigned IRQ_N = 8;
  localparam int unsigned TMR_W = 22;
  localparam int unsigned LEN_W = 11;
  localparam logic [PHYS_AW-1:0] SCRATCH_BASE = 18'h20000;
  localparam logic [LOG_AW-1:0] SCRATCH_LAST = 16'h00ff;
  localparam logic [LOG_AW-1:0] ERASE_BOTH_ADDR = 16'h0400;
  localparam logic [LEN_W-1:0] PAGE_LEN = 11'h400;
  localparam logic [LEN_W-1:0] SECTOR_LEN = 11'h080;
  localparam logic [LEN_W-1:0] BOTH_LEN = 11'h100;
  localparam logic [PHYS_AW-1:0] PAGE_MASK = 18'h3fc00;
  localparam logic [PHYS_AW-1:0] SECTOR_MASK = 18'h3ff80;
  localparam logic [PHYS_AW-1:0] WORD_MASK = 18'h3fffc;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [1:0] CODE_LAST_LANE = 2'h3;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned ERASE_TIME_MS = 12;
  localparam int unsigned WRITE_TIME_US = 50;
  localparam int unsigned ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {ST_IDLE, ST_RD_TAKE, ST_BUSY} fpec_state_type;
endpackage : fpec_pkg

// >>> design/fpec_timer.sv
/*
 Down-counter that times one flash erase or program operation.
 Assumes start_i is a one-cycle pulse and len_i is at least one.
*/
`timescale 1ns/1ps
module fpec_timer (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic [fpec_pkg::TMR_W-1:0] len_i,
  output logic done_o
);
  import fpec_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } fpec_tmr_type;

  fpec_tmr_type s_q;
  fpec_tmr_type s_d;

  always_comb begin
    s_d = s_q;
    if (start_i) begin
      s_d.cnt = len_i;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - TMR_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Hardware owns the timing, software never polls a counter
  assign done_o = (s_q.cnt == TMR_W'(1));
endmodule : fpec_timer

// >>> sim/flash_program_erase_control_tb.sv
/*
 Self-checking bench for the flash program/erase sequencer.
 Assumes the timing counts are shortened through the top's parameters.
*/
`timescale 1ns/1ps
module flash_program_erase_control_tb;
  import fpec_pkg::*;
  localparam int EC = 20;
  localparam int WC = 10;
  // Mode bits: flash enable, erase enable, write enable, scratch, block
  localparam logic [6:0] M_WR = 7'h50;
  localparam logic [6:0] M_ER = 7'h70;
  logic clk, rstn, dw_valid, dr_valid, cr_valid, cr_fetch;
  logic [6:0] mode;
  logic [15:0] dw_addr, dr_addr, cr_addr;
  logic [7:0] dw_data, irq_req, irq_cached, irq_ack;
  wire dw_ready, cr_ready, cr_rvalid, xwe, xre, frd, fprog, ferase, busy;
  wire [15:0] xwaddr, xraddr;
  wire [7:0] cr_data, xwdata, irq;
  wire [17:0] faddr;
  wire [31:0] fwdata, frdata;
  wire [3:0] fmask;
  wire [10:0] flen;
  logic s_busy, s_dwr, s_crr, s_xwe;
  logic [15:0] s_xaddr;
  logic [7:0] s_xdata;
  int failures, cmp_count, bcnt;

  fpec_ctrl #(.ERASE_CYCLES_P(EC), .WRITE_CYCLES_P(WC)) uut (
    .clk_i(clk), .rstn_i(rstn),
    .store_write_enable_i(mode[4]), .store_erase_enable_i(mode[5]),
    .software_flash_enable_i(mode[6]), .scratchpad_select_i(mode[3]),
    .block_write_select_i(mode[2]), .code_bank_field_i(mode[1:0]),
    .dw_valid_i(dw_valid), .dw_addr_i(dw_addr), .dw_data_i(dw_data),
    .dw_ready_o(dw_ready), .dr_valid_i(dr_valid), .dr_addr_i(dr_addr),
    .cr_valid_i(cr_valid), .cr_fetch_i(cr_fetch), .cr_addr_i(cr_addr),
    .cr_ready_o(cr_ready), .cr_rvalid_o(cr_rvalid), .cr_data_o(cr_data),
    .external_data_ram_we_o(xwe), .external_data_ram_waddr_o(xwaddr), .external_data_ram_wdata_o(xwdata),
    .external_data_ram_re_o(xre), .external_data_ram_raddr_o(xraddr), .fl_rd_o(frd),
    .fl_prog_o(fprog), .fl_erase_o(ferase), .fl_addr_o(faddr),
    .fl_wdata_o(fwdata), .fl_wmask_o(fmask), .fl_erase_len_o(flen),
    .fl_rdata_i(frdata), .irq_req_i(irq_req), .irq_cached_i(irq_cached),
    .irq_ack_i(irq_ack), .irq_o(irq), .flash_busy_flag_o(busy)
  );
  fpec_flash_model mdl (
    .clk_i(clk), .rd_i(frd), .prog_i(fprog), .erase_i(ferase),
    .addr_i(faddr), .wdata_i(fwdata), .wmask_i(fmask),
    .erase_len_i(flen), .rdata_o(frdata)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Busy is sampled mid-cycle so the count never races the edge
  always @(negedge clk) begin
    if (busy === 1'b1) bcnt++;
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask : chk

  task automatic report_and_stop;
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic dwrite(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    dw_valid = 1'b1;
    dw_addr = a;
    dw_data = d;
    bcnt = 0;
    #1;
    while (dw_ready !== 1'b1) begin
      @(negedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    {s_busy, s_dwr, s_crr, s_xwe} = {busy, dw_ready, cr_ready, xwe};
    {s_xaddr, s_xdata} = {xwaddr, xwdata};
    @(negedge clk);
    dw_valid = 1'b0;
  endtask : dwrite

  task automatic wait_idle;
    while (busy !== 1'b0) @(negedge clk);
  endtask : wait_idle

  task automatic fwrite(input logic [15:0] a, input logic [7:0] d);
    dwrite(a, d);
    wait_idle();
  endtask : fwrite

  task automatic dread(input logic [15:0] a);
    @(negedge clk);
    dr_valid = 1'b1;
    dr_addr = a;
    @(posedge clk);
    #1;
    chk("external_data_ram_re", 1, xre);
    chk("external_data_ram_raddr", a, xraddr);
    @(negedge clk);
    dr_valid = 1'b0;
  endtask : dread

  task automatic cread(input logic f, input logic [15:0] a,
                       input logic [7:0] e);
    @(negedge clk);
    cr_valid = 1'b1;
    cr_fetch = f;
    cr_addr = a;
    #1;
    while (cr_ready !== 1'b1) begin
      @(negedge clk);
      #1;
    end
    @(posedge clk);
    @(negedge clk);
    cr_valid = 1'b0;
    @(posedge clk);
    #1;
    chk("cr_rvalid", 1, cr_rvalid);
    chk("cr_data", e, cr_data);
  endtask : cread

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  initial begin
    {rstn, dw_valid, dr_valid, cr_valid, cr_fetch} = 5'h0;
    {mode, dw_addr, dr_addr, cr_addr, dw_data} = '0;
    {irq_req, irq_cached, irq_ack} = '0;
    failures = 0;
    cmp_count = 0;
    bcnt = 0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    #1;
    chk("busy_rst", 0, busy);
    chk("cr_ready_rst", 1, cr_ready);
    dwrite(16'h1234, 8'h5c);
    chk("external_data_ram_we", 1, s_xwe);
    chk("external_data_ram_waddr", 16'h1234, s_xaddr);
    chk("external_data_ram_wdata", 8'h5c, s_xdata);
    mode = M_WR;
    dread(16'h4321);
    dwrite(16'h0010, 8'ha5);
    chk("busy_wr", 1, s_busy);
    chk("dw_ready_busy", 0, s_dwr);
    chk("cr_ready_busy", 0, s_crr);
    wait_idle();
    chk("busy_len_wr", WC + 2, bcnt);
    cread(1'b0, 16'h0010, 8'ha5);
    fwrite(16'h0010, 8'h5a);
    cread(1'b0, 16'h0010, 8'h00);
    mode = 7'h10;
    dwrite(16'h0011, 8'h00);
    chk("busy_noen", 0, s_busy);
    chk("external_data_ram_we_noen", 0, s_xwe);
    cread(1'b0, 16'h0011, 8'hff);
    mode = M_WR;
    fwrite(16'h0400, 8'h11);
    mode = M_ER;
    irq_cached = 8'h10;
    dwrite(16'h0123, 8'h00);
    chk("busy_er", 1, s_busy);
    irq_req = 8'h1a;
    @(negedge clk);
    irq_req = 8'h00;
    #1;
    chk("irq_held", 8'h10, irq);
    wait_idle();
    chk("busy_len_er", EC + 1, bcnt);
    #1;
    chk("irq_first", 8'h02, irq);
    irq_ack = 8'h02;
    @(negedge clk);
    irq_ack = 8'h00;
    #1;
    chk("irq_next", 8'h08, irq);
    irq_ack = 8'h18;
    @(negedge clk);
    irq_ack = 8'h00;
    #1;
    chk("irq_none", 8'h00, irq);
    cread(1'b0, 16'h0010, 8'hff);
    cread(1'b0, 16'h03ff, 8'hff);
    cread(1'b0, 16'h0400, 8'h11);
    mode = M_WR | 7'h01;
    fwrite(16'h8000, 8'h22);
    mode = M_WR | 7'h02;
    fwrite(16'h8000, 8'h33);
    cread(1'b0, 16'h8000, 8'h33);
    cread(1'b0, 16'h0400, 8'h11);
    mode = M_WR | 7'h01;
    cread(1'b0, 16'h8000, 8'h22);
    mode = M_WR;
    cread(1'b0, 16'h8000, 8'hff);
    // The page was erased, so give lane 0 a programmed value to keep
    fwrite(16'h0010, 8'h5a);
    mode = M_WR | 7'h04;
    // Lane 0 padded with all-ones to keep the old byte
    for (int i = 0; i < 4; i++) begin
      dwrite(16'h0010 + 16'(i), (i == 0) ? 8'hff : 8'h43 + 8'(i));
      chk("busy_blk", (i == 3) ? 1 : 0, s_busy);
    end
    wait_idle();
    chk("busy_len_blk", WC + 2, bcnt);
    cread(1'b0, 16'h0010, 8'h5a);
    cread(1'b0, 16'h0013, 8'h46);
    mode = M_WR | 7'h08;
    fwrite(16'h0005, 8'h77);
    cread(1'b0, 16'h0005, 8'h77);
    cread(1'b1, 16'h0005, 8'hff);
    mode = M_WR;
    cread(1'b0, 16'h0005, 8'hff);
    mode = M_WR | 7'h0c;
    dwrite(16'h0080, 8'h66);
    chk("busy_sp0", 0, s_busy);
    dwrite(16'h0081, 8'h67);
    chk("busy_sp1", 1, s_busy);
    wait_idle();
    cread(1'b0, 16'h0080, 8'h66);
    mode = M_ER | 7'h08;
    fwrite(16'h0081, 8'h00);
    cread(1'b0, 16'h0080, 8'hff);
    cread(1'b0, 16'h0400, 8'hff);
    cread(1'b0, 16'h0005, 8'h77);
    fwrite(16'h0400, 8'h00);
    cread(1'b0, 16'h0005, 8'hff);
    report_and_stop();
  end
endmodule : flash_program_erase_control_tb

// >>> sim/fpec_flash_model.sv
/*
 Behavioural flash array on the far side of the sequencer.
 Assumes word-aligned commands and a single clock; unwritten bytes read
 as erased.
*/
`timescale 1ns/1ps
module fpec_flash_model (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic prog_i,
  input wire logic erase_i,
  input wire logic [17:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wmask_i,
  input wire logic [10:0] erase_len_i,
  output logic [31:0] rdata_o
);
  logic [7:0] mem [logic [17:0]];
  logic [31:0] last_q;
  function automatic logic [7:0] rd_byte(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : rd_byte
  // Outside a read the bus shows the inverse of the last word, so a
  // design that samples late cannot pass by luck
  always @* begin
    if (rd_i) begin
      rdata_o = {rd_byte(addr_i + 18'h3), rd_byte(addr_i + 18'h2),
                 rd_byte(addr_i + 18'h1), rd_byte(addr_i)};
    end else begin
      rdata_o = ~last_q;
    end
  end
  always @(posedge clk_i) begin
    if (rd_i) begin
      last_q <= rdata_o;
    end
    if (prog_i) begin
      for (int i = 0; i < 4; i++) begin
        if (wmask_i[i]) begin
          // Cells can only lose charge
          mem[addr_i + 18'(i)] = rd_byte(addr_i + 18'(i)) & wdata_i[8*i +: 8];
        end
      end
    end
    if (erase_i) begin
      for (int i = 0; i < int'(erase_len_i); i++) begin
        mem[addr_i + 18'(i)] = 8'hff;
      end
    end
  end
endmodule : fpec_flash_model
